/* File: rtl/ccpu_pkg.sv */
`default_nettype none
// =====================================================================
// Shared constants for the capture/compare/PWM channel
// =====================================================================
package ccpu_pkg;

    // =================================================================
    // Register offsets on the plain register port
    // =================================================================
    localparam logic [2:0] OFF_CTRL      = 3'h0; // Channel control
    localparam logic [2:0] OFF_VAL_LOW   = 3'h1; // Channel value, low byte
    localparam logic [2:0] OFF_VAL_HIGH  = 3'h2; // Channel value, high byte
    localparam logic [2:0] OFF_PER_LIMIT = 3'h3; // Period limit
    localparam logic [2:0] OFF_PER_CTRL  = 3'h4; // Period timer control
    localparam logic [2:0] OFF_PER_COUNT = 3'h5; // Period timer count
    localparam logic [2:0] OFF_STATUS    = 3'h6; // Sticky flags, write 1 clears

    // =================================================================
    // Field positions
    // =================================================================
    localparam int CTRL_MODE_LSB  = 0; // Mode field, four bits
    localparam int CTRL_DUTY_LSB  = 4; // Duty low bits, two bits
    localparam int PCTL_PRE_LSB   = 0; // Prescale select, two bits
    localparam int PCTL_RUN_BIT   = 2; // Period timer run
    localparam int PCTL_POST_LSB  = 3; // Postscale select, four bits
    localparam int STAT_EVENT_BIT = 0; // Channel event flag
    localparam int STAT_MATCH_BIT = 1; // Period match flag

    // =================================================================
    // Reset values
    // =================================================================
    localparam logic [7:0] RST_CTRL      = 8'h00;
    localparam logic [7:0] RST_VALUE     = 8'h00;
    localparam logic [7:0] RST_PER_LIMIT = 8'hFF;
    localparam logic [6:0] RST_PER_CTRL  = 7'h00;
    localparam logic [7:0] RST_PER_COUNT = 8'h00;
    localparam logic [7:0] RST_PRESCALE  = 8'h00;
    localparam logic [3:0] RST_CAP_COUNT = 4'h0;

    // =================================================================
    // Counts
    // =================================================================
    localparam logic [3:0] CAP_DIV4_LAST  = 4'h3; // Fourth rising edge
    localparam logic [3:0] CAP_DIV16_LAST = 4'hF; // Sixteenth rising edge

    // =================================================================
    // Channel modes
    // =================================================================
    typedef enum logic [3:0] {
        MODE_OFF       = 4'b0000,
        MODE_CMP_TOG   = 4'b0010,
        MODE_CAP_FALL  = 4'b0100,
        MODE_CAP_RISE  = 4'b0101,
        MODE_CAP_RISE4 = 4'b0110,
        MODE_CAP_RISE16 = 4'b0111,
        MODE_CMP_SET   = 4'b1000,
        MODE_CMP_CLR   = 4'b1001,
        MODE_CMP_SOFT  = 4'b1010,
        MODE_CMP_TRIG  = 4'b1011,
        MODE_PWM       = 4'b1100
    } ccpu_mode_e;

endpackage : ccpu_pkg
`default_nettype wire

/* File: rtl/ccpu_period_timer.sv */
`default_nettype none
// =====================================================================
// Eight-bit period timer with prescaler and ten-bit time base
// =====================================================================
module ccpu_period_timer (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       run,          // Timer enabled and not asleep
    input  wire logic [1:0] prescale,     // 4, 16, 64 or 256 clocks per count
    input  wire logic [7:0] period_limit, // Last count of a period
    input  wire logic       count_wr,     // Software loads the count
    input  wire logic [7:0] count_wdata,  // Value loaded
    output logic      [7:0] count,        // Period timer count
    output logic      [9:0] time_base,    // Count with two fraction bits
    output logic            period_end    // One-cycle pulse at wrap
);

    // =================================================================
    // Prescaler: clock cycles per count are 4, 16, 64 or 256
    // =================================================================
    logic [7:0] pre_q;     // Free prescaler count
    logic [7:0] pre_last;  // Terminal value for this setting
    logic       tick;      // Count advances this cycle

    // One prescaler serves all settings; its top used bits are the fraction
    always_comb begin
        unique case (prescale)
            2'b00: pre_last = 8'h03;
            2'b01: pre_last = 8'h0F;
            2'b10: pre_last = 8'h3F;
            2'b11: pre_last = 8'hFF;
        endcase
    end

    assign tick       = run && ((pre_q & pre_last) == pre_last);
    assign period_end = tick && (count == period_limit);

    // Fraction bits come from the prescaler position of the setting
    always_comb begin
        unique case (prescale)
            2'b00: time_base = {count, pre_q[1:0]};
            2'b01: time_base = {count, pre_q[3:2]};
            2'b10: time_base = {count, pre_q[5:4]};
            2'b11: time_base = {count, pre_q[7:6]};
        endcase
    end

    // Prescaler is cleared by a count write so the first step is whole
    always_ff @(posedge clk) begin
        if (!resetn || count_wr) begin
            pre_q <= ccpu_pkg::RST_PRESCALE;
        end else if (tick) begin
            pre_q <= 8'h00;
        end else if (run) begin
            pre_q <= pre_q + 8'h01;
        end
    end

    // Count: wraps to zero on the step after the limit
    always_ff @(posedge clk) begin
        if (!resetn) begin
            count <= ccpu_pkg::RST_PER_COUNT;
        end else if (count_wr) begin
            count <= count_wdata;
        end else if (period_end) begin
            count <= 8'h00;
        end else if (tick) begin
            count <= count + 8'h01;
        end
    end

endmodule : ccpu_period_timer
`default_nettype wire

/* File: rtl/ccpu_channel.sv */
`default_nettype none
// =====================================================================
// Capture/compare/PWM channel
// =====================================================================
module ccpu_channel (
    input  wire logic        clk,
    input  wire logic        resetn,
    // Register port
    input  wire logic [2:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_we,
    input  wire logic        reg_re,
    output logic      [7:0]  reg_rdata,
    // Wide timer, same clock domain
    input  wire logic [15:0] wide_timer_value,
    input  wire logic        wide_timer_tick,
    output logic             wide_timer_clear,
    // Converter and system
    output logic             adc_trigger,
    input  wire logic        sleep,
    // Channel pin
    input  wire logic        channel_pin_in,
    output logic             channel_pin_out,
    output logic             channel_pin_oe
);

    // =================================================================
    // Mode decoding
    // =================================================================
    // Capture modes share the 01xx codes
    function automatic logic is_capture(input logic [3:0] m);
        return m[3:2] == 2'b01;
    endfunction : is_capture

    // PWM owns every 11xx code
    function automatic logic is_pwm(input logic [3:0] m);
        return m[3:2] == 2'b11;
    endfunction : is_pwm

    // Compare modes, including the two that leave the pin alone
    function automatic logic is_compare(input logic [3:0] m);
        return (m == 4'b0010) || (m[3:2] == 2'b10);
    endfunction : is_compare

    // =================================================================
    // Registers
    // =================================================================
    logic [7:0] ctrl_q;        // Channel control register
    logic [7:0] val_low_q;     // Channel value, low byte
    logic [7:0] val_high_q;    // Channel value, high byte
    logic [7:0] per_limit_q;   // Period limit register
    logic [6:0] per_ctrl_q;    // Period timer control register
    logic       event_flag_q;  // Channel event flag
    logic       match_flag_q;  // Period match flag
    logic [3:0] post_cnt_q;    // Postscale count toward the match flag
    logic [1:0] duty_lat_q;    // Buffered duty low bits
    logic [3:0] cap_cnt_q;     // Capture event prescaler
    logic [2:0] pin_sync_q;    // Two-stage sync plus edge history
    logic       match_q;       // Compare match seen last cycle
    logic       cmp_latch_q;   // Compare output latch
    logic       pwm_q;         // PWM output level

    logic [3:0] mode;          // Mode field
    logic [1:0] duty_low;      // Duty low bits field
    logic       wr_ctrl;       // Write strobes per register
    logic       wr_low;
    logic       wr_high;
    logic       wr_limit;
    logic       wr_pctrl;
    logic       wr_count;
    logic       wr_status;

    assign mode      = ctrl_q[ccpu_pkg::CTRL_MODE_LSB +: 4];
    assign duty_low  = ctrl_q[ccpu_pkg::CTRL_DUTY_LSB +: 2];
    assign wr_ctrl   = reg_we && (reg_addr == ccpu_pkg::OFF_CTRL);
    assign wr_low    = reg_we && (reg_addr == ccpu_pkg::OFF_VAL_LOW);
    assign wr_high   = reg_we && (reg_addr == ccpu_pkg::OFF_VAL_HIGH);
    assign wr_limit  = reg_we && (reg_addr == ccpu_pkg::OFF_PER_LIMIT);
    assign wr_pctrl  = reg_we && (reg_addr == ccpu_pkg::OFF_PER_CTRL);
    assign wr_count  = reg_we && (reg_addr == ccpu_pkg::OFF_PER_COUNT);
    assign wr_status = reg_we && (reg_addr == ccpu_pkg::OFF_STATUS);

    // =================================================================
    // Period timer
    // =================================================================
    logic [7:0] per_count;     // Period timer count
    logic [9:0] time_base;     // Ten-bit PWM time base
    logic       period_end;    // Period wrap pulse

    // Period timer holds its count while asleep
    ccpu_period_timer u_period_timer (
        .clk          (clk),
        .resetn       (resetn),
        .run          (per_ctrl_q[ccpu_pkg::PCTL_RUN_BIT] && !sleep),
        .prescale     (per_ctrl_q[ccpu_pkg::PCTL_PRE_LSB +: 2]),
        .period_limit (per_limit_q),
        .count_wr     (wr_count),
        .count_wdata  (reg_wdata),
        .count        (per_count),
        .time_base    (time_base),
        .period_end   (period_end)
    );

    // =================================================================
    // Pin input synchroniser and capture event
    // =================================================================
    logic rise;                // Synced rising edge
    logic fall;                // Synced falling edge
    logic cap_event;           // Selected capture event

    // Pin is asynchronous; stage 0 feeds only stage 1
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pin_sync_q <= 3'b000;
        end else begin
            pin_sync_q <= {pin_sync_q[1:0], channel_pin_in};
        end
    end

    assign rise = pin_sync_q[1] && !pin_sync_q[2];
    assign fall = !pin_sync_q[1] && pin_sync_q[2];

    // Event select; sleep does not gate capture
    always_comb begin
        unique case (mode)
            ccpu_pkg::MODE_CAP_FALL:   cap_event = fall;
            ccpu_pkg::MODE_CAP_RISE:   cap_event = rise;
            ccpu_pkg::MODE_CAP_RISE4:
                cap_event = rise && (cap_cnt_q[1:0] == ccpu_pkg::CAP_DIV4_LAST[1:0]);
            ccpu_pkg::MODE_CAP_RISE16:
                cap_event = rise && (cap_cnt_q == ccpu_pkg::CAP_DIV16_LAST);
            default:                   cap_event = 1'b0;
        endcase
    end

    // Prescaler counts rising edges; a switch between divide settings
    // keeps the count, so software zeroes the control first
    always_ff @(posedge clk) begin
        if (!resetn || !is_capture(mode)) begin
            cap_cnt_q <= ccpu_pkg::RST_CAP_COUNT;
        end else if (cap_event) begin
            cap_cnt_q <= 4'h0;
        end else if (rise) begin
            cap_cnt_q <= cap_cnt_q + 4'h1;
        end
    end

    // =================================================================
    // Compare
    // =================================================================
    logic match_now;           // Timer equals channel value
    logic match_hit;           // New match this cycle

    // Compare runs on the system clock and stops in sleep
    assign match_now = is_compare(mode) && !sleep
                       && (wide_timer_value == {val_high_q, val_low_q});
    assign match_hit = match_now && !match_q;

    // One hit per match; the timer dwells on a value for many cycles
    always_ff @(posedge clk) begin
        if (!resetn) begin
            match_q <= 1'b0;
        end else begin
            match_q <= match_now;
        end
    end

    // Compare output latch
    always_ff @(posedge clk) begin
        if (!resetn || (wr_ctrl && reg_wdata == 8'h00)) begin
            cmp_latch_q <= 1'b0;
        end else if (match_hit) begin
            unique case (mode)
                ccpu_pkg::MODE_CMP_TOG: cmp_latch_q <= !cmp_latch_q;
                ccpu_pkg::MODE_CMP_SET: cmp_latch_q <= 1'b1;
                ccpu_pkg::MODE_CMP_CLR: cmp_latch_q <= 1'b0;
                default:                cmp_latch_q <= cmp_latch_q;
            endcase
        end
    end

    // Conversion trigger pulse, one cycle after the match
    always_ff @(posedge clk) begin
        if (!resetn) begin
            adc_trigger <= 1'b0;
        end else begin
            adc_trigger <= match_hit && (mode == ccpu_pkg::MODE_CMP_TRIG);
        end
    end

    // Timer clear request: held until the timer's next tick, dropped
    // if the match goes away first. It is a separate line from the
    // overflow path, so the timer's overflow flag stays untouched.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wide_timer_clear <= 1'b0;
        end else if (match_hit && mode == ccpu_pkg::MODE_CMP_TRIG) begin
            wide_timer_clear <= 1'b1;
        end else if (wide_timer_tick || !match_now) begin
            wide_timer_clear <= 1'b0;
        end
    end

    // =================================================================
    // Channel event flag
    // =================================================================
    // Set wins over a clearing write in the same cycle. A mode change
    // can see a stale edge and flag falsely; software clears it
    always_ff @(posedge clk) begin
        if (!resetn) begin
            event_flag_q <= 1'b0;
        end else if (cap_event || match_hit) begin
            event_flag_q <= 1'b1;
        end else if (wr_status && reg_wdata[ccpu_pkg::STAT_EVENT_BIT]) begin
            event_flag_q <= 1'b0;
        end
    end

    // =================================================================
    // PWM
    // =================================================================
    logic [9:0] duty_next;     // Duty as software wrote it
    logic       duty_hit;      // Time base sits at the buffered duty

    assign duty_next = {val_low_q, duty_low};
    // The pin level masks the hit cycle; a registered clear alone
    // would stretch every pulse by one clock
    assign duty_hit  = (time_base == {val_high_q, duty_lat_q});

    // Pin set at the wrap unless the duty is zero, cleared at the duty
    always_ff @(posedge clk) begin
        if (!resetn || !is_pwm(mode)) begin
            pwm_q <= 1'b0;
        end else if (period_end) begin
            pwm_q <= (duty_next != 10'h000);
        end else if (duty_hit) begin
            pwm_q <= 1'b0;
        end
    end

    // Low duty bits are double buffered like the high byte
    always_ff @(posedge clk) begin
        if (!resetn) begin
            duty_lat_q <= 2'b00;
        end else if (period_end && is_pwm(mode)) begin
            duty_lat_q <= duty_low;
        end
    end

    // Period match flag through the postscaler; set wins over clear
    always_ff @(posedge clk) begin
        if (!resetn) begin
            post_cnt_q   <= 4'h0;
            match_flag_q <= 1'b0;
        end else if (period_end && post_cnt_q == per_ctrl_q[ccpu_pkg::PCTL_POST_LSB +: 4]) begin
            post_cnt_q   <= 4'h0;
            match_flag_q <= 1'b1;
        end else begin
            if (period_end) begin
                post_cnt_q <= post_cnt_q + 4'h1;
            end
            // A clear is not lost to a wrap that leaves the flag alone
            if (wr_status && reg_wdata[ccpu_pkg::STAT_MATCH_BIT]) begin
                match_flag_q <= 1'b0;
            end
        end
    end

    // =================================================================
    // Pin drive
    // =================================================================
    // Software and trigger compare modes leave the pin to the port
    always_ff @(posedge clk) begin
        if (!resetn) begin
            channel_pin_out <= 1'b0;
            channel_pin_oe  <= 1'b0;
        end else begin
            channel_pin_out <= is_pwm(mode) ? (pwm_q && !duty_hit) : cmp_latch_q;
            channel_pin_oe  <= is_pwm(mode) || mode == ccpu_pkg::MODE_CMP_TOG
                               || mode == ccpu_pkg::MODE_CMP_SET
                               || mode == ccpu_pkg::MODE_CMP_CLR;
        end
    end

    // =================================================================
    // Register writes
    // =================================================================
    // Control and period registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl_q      <= ccpu_pkg::RST_CTRL;
            per_limit_q <= ccpu_pkg::RST_PER_LIMIT;
            per_ctrl_q  <= ccpu_pkg::RST_PER_CTRL;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= {2'b00, reg_wdata[5:0]};
            end
            if (wr_limit) begin
                per_limit_q <= reg_wdata;
            end
            if (wr_pctrl) begin
                per_ctrl_q <= reg_wdata[6:0];
            end
        end
    end

    // Value pair: capture beats a same-cycle software write
    always_ff @(posedge clk) begin
        if (!resetn) begin
            val_low_q  <= ccpu_pkg::RST_VALUE;
            val_high_q <= ccpu_pkg::RST_VALUE;
        end else if (cap_event) begin
            val_low_q  <= wide_timer_value[7:0];
            val_high_q <= wide_timer_value[15:8];
        end else begin
            if (wr_low) begin
                val_low_q <= reg_wdata;
            end
            if (is_pwm(mode)) begin
                if (period_end) begin
                    val_high_q <= val_low_q;
                end
            end else if (wr_high) begin
                val_high_q <= reg_wdata;
            end
        end
    end

    // =================================================================
    // Register reads, data one cycle after the strobe
    // =================================================================
    always_ff @(posedge clk) begin
        if (!resetn || !reg_re) begin
            reg_rdata <= 8'h00;
        end else begin
            unique case (reg_addr)
                ccpu_pkg::OFF_CTRL:      reg_rdata <= ctrl_q;
                ccpu_pkg::OFF_VAL_LOW:   reg_rdata <= val_low_q;
                ccpu_pkg::OFF_VAL_HIGH:  reg_rdata <= val_high_q;
                ccpu_pkg::OFF_PER_LIMIT: reg_rdata <= per_limit_q;
                ccpu_pkg::OFF_PER_CTRL:  reg_rdata <= {1'b0, per_ctrl_q};
                ccpu_pkg::OFF_PER_COUNT: reg_rdata <= per_count;
                ccpu_pkg::OFF_STATUS:    reg_rdata <= {6'h00, match_flag_q, event_flag_q};
                default:                 reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule : ccpu_channel
`default_nettype wire

/* File: testbench/ccpu_channel_checker.sv */
`default_nettype none
// ==========
// Port checker
module ccpu_channel_checker (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       reg_we,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       wide_timer_tick,
    input wire logic       wide_timer_clear,
    input wire logic       adc_trigger,
    input wire logic       channel_pin_out,
    input wire logic       channel_pin_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] mode_q;                               // Last mode written
    wire        ctl_wr = reg_we && reg_addr == 3'h0;  // Control write
    // Shadow of the mode, so pin rules can be tied to it
    always_ff @(posedge clk) begin
        if (!resetn)
            mode_q <= 4'h0;
        else if (ctl_wr)
            mode_q <= reg_wdata[3:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_trig_single: assert property (adc_trigger |=> !adc_trigger)
        else $error("trigger too long");
    a_trig_cause: assert property (adc_trigger |-> $past(mode_q) == 4'hB)
        else $error("trigger in wrong mode");
    a_trig_clear: assert property (adc_trigger |-> wide_timer_clear)
        else $error("trigger without timer reset");
    a_clear_tick: assert property (wide_timer_clear && wide_timer_tick
        |=> !wide_timer_clear) else $error("timer reset held");
    a_soft_pin: assert property (ctl_wr && reg_wdata[3:0] == 4'hA
        |=> ##1 !channel_pin_oe) else $error("pin taken");
    a_conv_pin: assert property (ctl_wr && reg_wdata[3:0] == 4'hB
        |=> ##1 !channel_pin_oe) else $error("pin taken");
    a_zero_latch: assert property (ctl_wr && reg_wdata == 8'h00 && mode_q[3:2] != 2'b11
        |=> ##1 !channel_pin_out) else $error("latch not low");
    a_reset_state: assert property (disable iff (1'b0) !resetn
        |=> !adc_trigger && !channel_pin_oe && reg_rdata == 8'h00) else $error("reset");
    c_trig: cover property (adc_trigger);
    c_pin: cover property ($rose(channel_pin_out));
    c_reset: cover property (wide_timer_clear && wide_timer_tick);
endmodule : ccpu_channel_checker
bind ccpu_channel ccpu_channel_checker i_ccpu_channel_checker (.*);
`default_nettype wire

/* File: testbench/ccpu_pin_src.sv */
`default_nettype none
// ==========
// Outside pin source and wide timer
module ccpu_pin_src (
    input  wire logic        clk,
    input  wire logic        channel_pin_out,
    input  wire logic        channel_pin_oe,
    input  wire logic        wide_timer_clear,
    output logic             channel_pin_in,
    output logic             wide_timer_tick,
    output logic      [15:0] wide_timer_value
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       src = 1'b0; // Level from outside
    logic       run = 1'b0; // Timer enabled
    logic [1:0] div = 2'h0; // Quarter-rate divider
    assign channel_pin_in  = channel_pin_oe ? channel_pin_out : src; // Wire level
    assign wide_timer_tick = run && div == 2'h3; // Synchronous quarter rate
    // Reset on request raises no overflow flag here
    always @(posedge clk) begin
        div <= div + 2'h1;
        if (wide_timer_tick)
            wide_timer_value <= wide_timer_clear ? 16'h0000 : wide_timer_value + 16'h0001;
    end
    // Load skips tick edges so the count never races
    task automatic set_timer(input logic [15:0] tv, input logic r);
        @(posedge clk);
        while (wide_timer_tick) @(posedge clk);
        wide_timer_value <= tv;
        run <= r;
    endtask : set_timer
    // Pulses of four clocks high, four low
    task automatic edges(input int n);
        repeat (n) begin
            src <= 1'b1;
            repeat (4) @(posedge clk);
            src <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask : edges
endmodule : ccpu_pin_src
`default_nettype wire

/* File: testbench/tb_ccpu_channel.sv */
`default_nettype none
// ==========
// Channel bench
module tb_ccpu_channel;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
    $display("Error at %0t: got %0h want %0h", $time, a, e); end end
    logic        clk = 1'b0, resetn = 1'b0, reg_we = 1'b0, reg_re = 1'b0, sleep = 1'b0;
    logic [2:0]  reg_addr = 3'h0;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata, v;
    logic [15:0] wide_timer_value;
    logic        wide_timer_tick, wide_timer_clear, adc_trigger;
    logic        channel_pin_in, channel_pin_out, channel_pin_oe;
    logic [3:0]  cm [5] = '{4'h2, 4'h8, 4'h9, 4'hA, 4'hB}; // Compare modes
    int          n_mismatch = 0, tests_run = 0, k, n_trig = 0;
    ccpu_channel i_ccpu_channel (.*);
    ccpu_pin_src i_ccpu_pin_src (.*);
    always #50 clk = ~clk;
    always @(posedge clk) n_trig += int'(adc_trigger); // Trigger pulses seen
    task automatic print_verdict;
        $display("%0d checks, %0d mismatches", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a; reg_wdata <= d; reg_we <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask : wr
    // Data stand only in the cycle after the strobe
    task automatic rc(input logic [2:0] a, input logic [7:0] e, input logic cmp);
        @(posedge clk);
        reg_addr <= a; reg_re <= 1'b1;
        @(posedge clk);
        reg_re <= 1'b0;
        #1 v = reg_rdata;
        if (cmp) `CHK(v, e)
    endtask : rc
    // Off write between settings drops a partial count
    task automatic cap(input logic [3:0] m, input int n);
        wr(3'h0, {4'h0, m});
        i_ccpu_pin_src.edges(n - 1);
        wr(3'h0, 8'h00);
        wr(3'h0, {4'h0, m});
        wr(3'h6, 8'h03);
        i_ccpu_pin_src.edges(n - 1);
        rc(3'h6, 8'h00, 1'b1);
        wr(3'h1, 8'h00); wr(3'h2, 8'h00); // Stale value must not pass
        i_ccpu_pin_src.edges(1);
        rc(3'h6, 8'h01, 1'b1);
        rc(3'h1, 8'h34, 1'b1);
        rc(3'h2, 8'h12, 1'b1);
    endtask : cap
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        wr(3'h7, 8'hFF);
        rc(3'h3, 8'hFF, 1'b1);
        rc(3'h7, 8'h00, 1'b1);
        $display("reset test done");
        i_ccpu_pin_src.set_timer(16'h1234, 1'b0);
        @(posedge clk) sleep <= 1'b1;
        cap(4'h4, 1); cap(4'h5, 1);
        @(posedge clk) sleep <= 1'b0;
        cap(4'h6, 4); cap(4'h7, 16);
        $display("capture test done");
        foreach (cm[i]) begin
            wr(3'h0, 8'h00); wr(3'h1, 8'h20); wr(3'h2, 8'h00);
            `CHK(channel_pin_out, 1'b0)
            i_ccpu_pin_src.set_timer(16'h0000, 1'b1);
            wr(3'h0, {4'h0, cm[i]});
            wr(3'h6, 8'h03);
            k = 0;
            do begin rc(3'h6, 8'h00, 1'b0); k++; end while (v[0] !== 1'b1 && k < 100);
            `CHK(v[0], 1'b1)
            if (v[0] !== 1'b1) print_verdict();
            repeat (3) @(negedge clk);
            `CHK(channel_pin_out, cm[i] inside {4'h2, 4'h8})
            `CHK(channel_pin_oe, cm[i] inside {4'h2, 4'h8, 4'h9})
            `CHK(n_trig != 0, cm[i] == 4'hB)
            `CHK(wide_timer_value >= 16'h0020, cm[i] != 4'hB)
        end
        $display("compare test done");
        wr(3'h0, 8'h00); wr(3'h3, 8'h03); wr(3'h0, 8'h1C);
        wr(3'h1, 8'h01); wr(3'h6, 8'h03); wr(3'h4, 8'h04);
        for (int d = 1; d >= 0; d--) begin
            repeat (40) @(posedge clk);
            k = 0;
            repeat (64) @(posedge clk) k += int'(channel_pin_out);
            `CHK(k, 20 * d)
            rc(3'h6, 8'h02, 1'b1);
            wr(3'h2, 8'h55);
            rc(3'h2, 8'(d), 1'b1);
            wr(3'h1, 8'h00); wr(3'h0, 8'h0C);
        end
        $display("pulse test done");
        print_verdict();
    end
endmodule : tb_ccpu_channel
`default_nettype wire
